// *** hw/ctc_regs.svh ***
// Register offsets, field positions, reset values and timing counts
//
// Contract
// - Timer and detection register at 0x15, resets to 0x5C.
// - Charge enable and watchdog register at 0x16, resets to 0xA1.
// - Converter and protection register at 0x17, resets to 0x4F.
// - Bit 7 of timer register disables the indicator pin when one.
// - Auto detect bit one starts port detection on input plug-in.
// - Force detect bit starts detection, self-clears when detection finishes.
// - Bias enable and dedicated port code 011b apply 600 mV D+ bias.
// - Half-speed bit slows safety timers during input or thermal regulation.
// - Safety timer enable bit turns charge safety timers on or off.
// - Pre-charge limit is 2 hrs when zero, 0.5 hrs when one.
// - Fast-charge limit is 12 hrs when zero, 24 hrs when one.
// - Overvoltage fault discharges battery only when auto discharge enabled.
// - Forced battery discharge bit draws about 30 mA from battery.
// - Mid-node discharge bit enables about 30 mA on mid-supply node.
// - Charging enable bit permits charging when one, stops when zero.
// - Kick bit restarts watchdog then self-clears; host kicks before expiry.
// - Restore bit returns registers to defaults, resets timers, self-clears.
`ifndef CTC_REGS_SVH
`define CTC_REGS_SVH
`define CTC_I2C_ADDR 7'h6A
`define CTC_OFS_TIMER 8'h15
`define CTC_OFS_CHGWD 8'h16
`define CTC_OFS_CONV 8'h17
`define CTC_OFS_STATUS 8'h1F
`define CTC_RST_TIMER 8'h5C
`define CTC_RST_CHGWD 8'hA1
`define CTC_RST_CONV 8'h4F
`define CTC_B_INDDIS 7
`define CTC_B_AUTODET 6
`define CTC_B_FORCEDET 5
`define CTC_B_BIAS 4
`define CTC_B_HALF 3
`define CTC_B_SAFE 2
`define CTC_B_PRESEL 1
`define CTC_B_FASTSEL 0
`define CTC_B_AUTODIS 7
`define CTC_B_BATDIS 6
`define CTC_B_CHGEN 5
`define CTC_B_MIDDIS 3
`define CTC_B_KICK 2
`define CTC_B_RESTORE 7
`define CTC_DCP_CODE 3'h3
`define CTC_CLK_HZ 200000000
`define CTC_WD_BASE_S 40
`define CTC_PRE_LONG_MIN 120
`define CTC_PRE_SHORT_MIN 30
`define CTC_FAST_SHORT_MIN 720
`define CTC_FAST_LONG_MIN 1440
`endif

// *** hw/ctc_pkg.sv ***
// Types shared by the charger timer control block
package ctc_pkg;
  typedef enum logic [2:0] {
    CTC_IDLE, CTC_ADDR, CTC_ACK, CTC_DATA, CTC_DACK, CTC_SEND, CTC_RACK
  } ctc_i2c_e;
  typedef logic [7:0] ctc_byte_t;
endpackage

// *** hw/ctc_timer_regs.sv ***
// I2C register bank with watchdog, safety timers and detection control
`timescale 1ns/100ps
`include "ctc_regs.svh"
module ctc_timer_regs #(
  parameter logic [39:0] WD_TICKS = 40'd8000000000,
  parameter logic [39:0] MIN_TICKS = 40'd12000000000
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic inputPlugged,
  input wire logic detectDone,
  input wire logic [2:0] inputSourceType,
  input wire logic inputRegActive,
  input wire logic thermalRegActive,
  input wire logic batteryOvpFault,
  input wire logic inPrecharge,
  input wire logic inFastCharge,
  output logic indicatorEnable,
  output logic portDetectStart,
  output logic dedicatedPortBias,
  output logic batteryDischarge,
  output logic midNodeDischarge,
  output logic chargeAllowed,
  output logic safetyTimerExpired,
  output logic watchdogFault,
  output ctc_pkg::ctc_byte_t convCfg
);
  import ctc_pkg::*;

  // Two-stage synchronisers on pins
  logic [1:0] sclSync, sdaSync, plugSync;
  logic sclPrev, sdaPrev;
  wire logic scl = sclSync[1];
  wire logic sda = sdaSync[1];
  wire logic sclRise = scl & ~sclPrev;
  wire logic sclFall = ~scl & sclPrev;
  wire logic startCond = scl & sclPrev & sdaPrev & ~sda;
  wire logic stopCond = scl & sclPrev & ~sdaPrev & sda;

  ctc_i2c_e state, next_state;
  logic [7:0] shift, next_shift;
  logic [2:0] bitCnt, next_bitCnt;
  logic readMode, next_readMode;
  logic haveIndex, next_haveIndex;
  logic [7:0] index, next_index;
  logic sdaLow, next_sdaLow;
  logic wrStrobe, next_wrStrobe;
  logic [7:0] wrData, next_wrData;
  logic gotBit, next_gotBit;

  logic [7:0] timerCfg, next_timerCfg;
  logic [7:0] chgWdCfg, next_chgWdCfg;
  logic [7:0] convReg, next_convReg;
  logic wdFlag, next_wdFlag;
  logic [39:0] wdCount, next_wdCount;
  // One minute of clocks needs more than 32 bits
  logic [39:0] tickCount, next_tickCount;
  logic halfPhase, next_halfPhase;
  logic [10:0] minutes, next_minutes;
  logic plugPrev, detStart, next_detStart;
  logic restoring, next_restoring;

  function automatic logic [7:0] read_reg(input logic [7:0] ofs,
    input logic [7:0] t, input logic [7:0] c, input logic [7:0] v,
    input logic f);
    case (ofs)
      `CTC_OFS_TIMER: read_reg = t;
      `CTC_OFS_CHGWD: read_reg = c;
      `CTC_OFS_CONV: read_reg = v;
      `CTC_OFS_STATUS: read_reg = {7'h00, f};
      default: read_reg = 8'h00;
    endcase
  endfunction

  function automatic logic [39:0] wd_limit(input logic [1:0] code);
    case (code)
      2'h1: wd_limit = WD_TICKS;
      2'h2: wd_limit = WD_TICKS << 1;
      2'h3: wd_limit = WD_TICKS << 2;
      default: wd_limit = 40'h00;
    endcase
  endfunction

  // I2C slave: address, index, then data; every written byte goes to the same index, a read returns one byte
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bitCnt = bitCnt;
    next_readMode = readMode;
    next_haveIndex = haveIndex;
    next_index = index;
    next_sdaLow = sdaLow;
    next_wrStrobe = 1'b0;
    next_wrData = wrData;
    next_gotBit = gotBit;
    if (startCond) begin
      next_state = CTC_ADDR;
      next_bitCnt = 3'h0;
      next_gotBit = 1'b0;
      next_haveIndex = 1'b0;
      next_sdaLow = 1'b0;
    end else if (stopCond) begin
      next_state = CTC_IDLE;
      next_sdaLow = 1'b0;
    end else begin
      case (state)
        CTC_IDLE: next_sdaLow = 1'b0;
        CTC_ADDR, CTC_DATA: begin
          if (sclRise) begin
            next_shift = {shift[6:0], sda};
            next_bitCnt = bitCnt + 3'h1;
            next_gotBit = 1'b1;
          end
          // Only a fall after a full byte ends it, not the fall after START
          if (sclFall && bitCnt == 3'h0 && gotBit) begin
            next_gotBit = 1'b0;
            if (state == CTC_ADDR && shift[7:1] == `CTC_I2C_ADDR) begin
              next_readMode = shift[0];
              next_sdaLow = 1'b1;
              next_state = CTC_ACK;
            end else if (state == CTC_ADDR) begin
              next_state = CTC_IDLE;
            end else begin
              next_sdaLow = 1'b1;
              next_state = CTC_DACK;
              if (haveIndex) begin
                next_wrStrobe = 1'b1;
                next_wrData = shift;
              end else begin
                next_index = shift;
                next_haveIndex = 1'b1;
              end
            end
          end
        end
        CTC_ACK: if (sclFall) begin
          if (readMode) begin
            next_shift = read_reg(index, timerCfg, chgWdCfg, convReg, wdFlag);
            next_sdaLow = ~next_shift[7];
            next_state = CTC_SEND;
          end else begin
            next_sdaLow = 1'b0;
            next_state = CTC_DATA;
          end
        end
        CTC_DACK: if (sclFall) begin
          next_sdaLow = 1'b0;
          next_state = CTC_DATA;
        end
        CTC_SEND: begin
          if (sclRise)
            next_bitCnt = bitCnt + 3'h1;
          if (sclFall && bitCnt == 3'h0) begin
            next_sdaLow = 1'b0;
            next_state = CTC_RACK;
          end else if (sclFall) begin
            next_shift = {shift[6:0], 1'b0};
            next_sdaLow = ~shift[6];
          end
        end
        CTC_RACK: if (sclRise) next_state = CTC_IDLE;
        default: next_state = CTC_IDLE;
      endcase
    end
  end

  // Register bank, watchdog and timers
  always_comb begin
    logic kick;
    logic slow;
    logic [10:0] limit;
    kick = 1'b0;
    slow = 1'b0;
    limit = 11'h000;
    next_timerCfg = timerCfg;
    next_chgWdCfg = chgWdCfg;
    next_convReg = convReg;
    next_wdFlag = wdFlag;
    next_wdCount = wdCount;
    next_tickCount = tickCount;
    next_halfPhase = halfPhase;
    next_minutes = minutes;
    next_detStart = 1'b0;
    next_restoring = 1'b0;
    if (wrStrobe) begin
      case (index)
        `CTC_OFS_TIMER: next_timerCfg = wrData;
        `CTC_OFS_CHGWD: next_chgWdCfg = wrData;
        `CTC_OFS_CONV: next_convReg = wrData;
        `CTC_OFS_STATUS: next_wdFlag = wdFlag & ~wrData[0];
        default: ;
      endcase
      kick = 1'b1;
    end
    if (wrStrobe && index == `CTC_OFS_TIMER && wrData[`CTC_B_FORCEDET])
      next_detStart = 1'b1;
    if (plugSync[1] && !plugPrev && timerCfg[`CTC_B_AUTODET])
      next_detStart = 1'b1;
    if (detectDone)
      next_timerCfg[`CTC_B_FORCEDET] = 1'b0;
    if (chgWdCfg[`CTC_B_KICK]) begin
      kick = 1'b1;
      next_chgWdCfg[`CTC_B_KICK] = 1'b0;
    end
    if (kick || chgWdCfg[1:0] == 2'h0)
      next_wdCount = 40'h00;
    else if (wdCount + 40'h1 >= wd_limit(chgWdCfg[1:0])) begin
      next_wdFlag = 1'b1;
      next_wdCount = 40'h00;
      next_timerCfg = `CTC_RST_TIMER;
      next_timerCfg[`CTC_B_INDDIS] = timerCfg[`CTC_B_INDDIS];
      next_timerCfg[`CTC_B_HALF] = timerCfg[`CTC_B_HALF];
      next_timerCfg[1:0] = timerCfg[1:0];
      next_chgWdCfg[6:3] = 4'h4;
    end else
      next_wdCount = wdCount + 40'h1;
    // Safety timers in minutes, half rate under regulation
    slow = timerCfg[`CTC_B_HALF] & (inputRegActive | thermalRegActive);
    if (inPrecharge)
      limit = timerCfg[`CTC_B_PRESEL] ? 11'(`CTC_PRE_SHORT_MIN) :
              11'(`CTC_PRE_LONG_MIN);
    else
      limit = timerCfg[`CTC_B_FASTSEL] ? 11'(`CTC_FAST_LONG_MIN) :
              11'(`CTC_FAST_SHORT_MIN);
    if (!timerCfg[`CTC_B_SAFE] || !(inPrecharge || inFastCharge)) begin
      next_tickCount = 40'h00;
      next_minutes = 11'h000;
      next_halfPhase = 1'b0;
    end else if (tickCount + 40'h1 >= MIN_TICKS) begin
      next_tickCount = 40'h00;
      next_halfPhase = slow ? ~halfPhase : 1'b0;
      if ((!slow || halfPhase) && minutes < limit)
        next_minutes = minutes + 11'h001;
    end else
      next_tickCount = tickCount + 40'h1;
    if (convReg[`CTC_B_RESTORE]) begin
      next_timerCfg = `CTC_RST_TIMER;
      next_chgWdCfg = `CTC_RST_CHGWD;
      next_convReg = `CTC_RST_CONV;
      next_wdCount = 40'h00;
      next_tickCount = 40'h00;
      next_minutes = 11'h000;
      next_restoring = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      plugSync <= 2'h0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      plugPrev <= 1'b0;
      state <= CTC_IDLE;
      shift <= 8'h00;
      bitCnt <= 3'h0;
      readMode <= 1'b0;
      haveIndex <= 1'b0;
      index <= 8'h00;
      sdaLow <= 1'b0;
      wrStrobe <= 1'b0;
      wrData <= 8'h00;
      gotBit <= 1'b0;
      timerCfg <= `CTC_RST_TIMER;
      chgWdCfg <= `CTC_RST_CHGWD;
      convReg <= `CTC_RST_CONV;
      wdFlag <= 1'b0;
      wdCount <= 40'h00;
      tickCount <= 40'h00;
      halfPhase <= 1'b0;
      minutes <= 11'h000;
      detStart <= 1'b0;
      restoring <= 1'b0;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      plugSync <= {plugSync[0], inputPlugged};
      sclPrev <= scl;
      sdaPrev <= sda;
      plugPrev <= plugSync[1];
      state <= next_state;
      shift <= next_shift;
      bitCnt <= next_bitCnt;
      readMode <= next_readMode;
      haveIndex <= next_haveIndex;
      index <= next_index;
      sdaLow <= next_sdaLow;
      wrStrobe <= next_wrStrobe;
      wrData <= next_wrData;
      gotBit <= next_gotBit;
      timerCfg <= next_timerCfg;
      chgWdCfg <= next_chgWdCfg;
      convReg <= next_convReg;
      wdFlag <= next_wdFlag;
      wdCount <= next_wdCount;
      tickCount <= next_tickCount;
      halfPhase <= next_halfPhase;
      minutes <= next_minutes;
      detStart <= next_detStart;
      restoring <= next_restoring;
    end
  end

  // Registered outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sdaOut <= 1'b0;
      sdaOe_n <= 1'b1;
      indicatorEnable <= 1'b1;
      portDetectStart <= 1'b0;
      dedicatedPortBias <= 1'b0;
      batteryDischarge <= 1'b0;
      midNodeDischarge <= 1'b0;
      chargeAllowed <= 1'b0;
      safetyTimerExpired <= 1'b0;
      watchdogFault <= 1'b0;
      convCfg <= `CTC_RST_CONV;
    end else begin
      sdaOut <= 1'b0;
      sdaOe_n <= ~sdaLow;
      indicatorEnable <= ~timerCfg[`CTC_B_INDDIS];
      portDetectStart <= detStart;
      dedicatedPortBias <= timerCfg[`CTC_B_BIAS] &
        (inputSourceType == `CTC_DCP_CODE);
      batteryDischarge <= chgWdCfg[`CTC_B_BATDIS] |
        (batteryOvpFault & chgWdCfg[`CTC_B_AUTODIS]);
      midNodeDischarge <= chgWdCfg[`CTC_B_MIDDIS];
      chargeAllowed <= chgWdCfg[`CTC_B_CHGEN] &
        ~safetyTimerExpired;
      safetyTimerExpired <= timerCfg[`CTC_B_SAFE] && (inPrecharge ?
        minutes >= 11'(timerCfg[`CTC_B_PRESEL] ? `CTC_PRE_SHORT_MIN :
        `CTC_PRE_LONG_MIN) : inFastCharge && minutes >= 11'(
        timerCfg[`CTC_B_FASTSEL] ? `CTC_FAST_LONG_MIN :
        `CTC_FAST_SHORT_MIN));
      watchdogFault <= wdFlag;
      convCfg <= {1'b0, convReg[6:0]};
    end
  end
endmodule // ctc_timer_regs

// *** tb/ctc_properties.sv ***
// Port properties of the charger timer control register bank
`timescale 1ns/100ps
`include "ctc_regs.svh"
module ctc_properties #(
  parameter logic [39:0] WD_TICKS = 40'h1DCD65000,
  parameter logic [39:0] MIN_TICKS = 40'd12000000000
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaOe_n,
  input wire logic [2:0] inputSourceType,
  input wire logic inPrecharge,
  input wire logic inFastCharge,
  input wire logic indicatorEnable,
  input wire logic portDetectStart,
  input wire logic dedicatedPortBias,
  input wire logic chargeAllowed,
  input wire logic safetyTimerExpired,
  input wire logic watchdogFault,
  input wire ctc_pkg::ctc_byte_t convCfg
);
  import ctc_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_expired;
    safetyTimerExpired [*2];
  endsequence
  sequence s_no_phase;
    (!inPrecharge && !inFastCharge) [*3];
  endsequence
  a_sda_scl_low: assert property (
    $changed(sdaOe_n) |-> !sclIn)
    else $error("sda moved while scl high");
  a_bias_dcp: assert property (
    (inputSourceType != `CTC_DCP_CODE) [*2] |-> !dedicatedPortBias)
    else $error("bias without dedicated port");
  a_detect_pulse: assert property (
    portDetectStart |=> !portDetectStart)
    else $error("detect start longer than one cycle");
  a_expired_blocks: assert property (
    s_expired |-> !chargeAllowed)
    else $error("charging during safety expiry");
  a_phase_idle: assert property (
    s_no_phase |-> !safetyTimerExpired)
    else $error("expiry outside charge phase");
  a_fault_clear: assert property (
    $fell(watchdogFault) |-> !sclIn)
    else $error("fault cleared without a write");
  a_ind_write: assert property (
    $changed(indicatorEnable) |-> !sclIn)
    else $error("indicator moved without a write");
  a_conv_write: assert property (
    $changed(convCfg) |-> !sclIn)
    else $error("converter config moved without a write");
endmodule // ctc_properties
bind ctc_timer_regs ctc_properties #(.WD_TICKS(WD_TICKS),
  .MIN_TICKS(MIN_TICKS)) props (.clock, .reset, .sclIn, .sdaOe_n,
  .inputSourceType, .inPrecharge, .inFastCharge, .indicatorEnable,
  .portDetectStart, .dedicatedPortBias, .chargeAllowed,
  .safetyTimerExpired, .watchdogFault, .convCfg);

// *** tb/ctc_i2c_host.sv ***
// I2C controller model issuing single-byte register transfers
`timescale 1ns/100ps
`include "ctc_regs.svh"
module ctc_i2c_host (
  input wire logic clock,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sdaLow,
  output logic rdValid,
  output logic [7:0] rdData
);
  int q = 10;
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
    rdValid = 1'b0;
    rdData = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bitIo(input logic b, output logic r);
    sdaLow <= !b;
    tick(q);
    sclOut <= 1'b1;
    tick(q);
    r = sdaIn;
    tick(q);
    sclOut <= 1'b0;
    tick(q);
  endtask
  // Also serves as repeated start
  task automatic start();
    sdaLow <= 1'b0;
    tick(q);
    sclOut <= 1'b1;
    tick(q);
    sdaLow <= 1'b1;
    tick(q);
    sclOut <= 1'b0;
    tick(q);
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    tick(q);
    sclOut <= 1'b1;
    tick(q);
    sdaLow <= 1'b0;
    tick(q);
  endtask
  task automatic xfer(input logic [7:0] w, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bitIo(w[i], r[i]);
    bitIo(1'b1, a);
  endtask
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({`CTC_I2C_ADDR, 1'b0}, r);
    xfer(a, r);
    xfer(d, r);
    stop();
  endtask
  task automatic readReg(input logic [7:0] a);
    logic [7:0] r;
    start();
    xfer({`CTC_I2C_ADDR, 1'b0}, r);
    xfer(a, r);
    start();
    xfer({`CTC_I2C_ADDR, 1'b1}, r);
    xfer(8'hFF, r);
    rdData <= r;
    rdValid <= 1'b1;
    tick(1);
    rdValid <= 1'b0;
    stop();
  endtask
endmodule // ctc_i2c_host

// *** tb/tb_top.sv ***
// Self-checking bench for the charger timer control register bank
`timescale 1ns/100ps
`include "ctc_regs.svh"
module tb_top;
  import ctc_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic inputPlugged = 1'b0;
  logic detectDone = 1'b0;
  logic [2:0] inputSourceType = 3'h0;
  logic inputRegActive = 1'b0;
  logic thermalRegActive = 1'b0;
  logic batteryOvpFault = 1'b0;
  logic inPrecharge = 1'b0;
  logic inFastCharge = 1'b0;
  logic sclIn, sdaOut, sdaOe_n, sdaLow, rdValid, indicatorEnable;
  logic portDetectStart, dedicatedPortBias, batteryDischarge;
  logic midNodeDischarge, chargeAllowed, safetyTimerExpired, watchdogFault;
  logic [7:0] rdData, t, c, v;
  ctc_byte_t convCfg;
  ctc_byte_t expQ[$];
  int nMismatch = 0;
  int checkCount = 0;
  wire sdaWire = !(sdaLow || (!sdaOe_n && !sdaOut));
  ctc_timer_regs #(.WD_TICKS(40'h2EE0), .MIN_TICKS(40'h32)) dut (
    .clock, .reset, .sclIn, .sdaIn(sdaWire), .sdaOut, .sdaOe_n,
    .inputPlugged, .detectDone, .inputSourceType, .inputRegActive,
    .thermalRegActive, .batteryOvpFault, .inPrecharge, .inFastCharge,
    .indicatorEnable, .portDetectStart, .dedicatedPortBias,
    .batteryDischarge, .midNodeDischarge, .chargeAllowed,
    .safetyTimerExpired, .watchdogFault, .convCfg);
  ctc_i2c_host host (.clock, .sdaIn(sdaWire), .sclOut(sclIn), .sdaLow,
    .rdValid, .rdData);
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
    checkCount++;
    if (g !== e) begin
      nMismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic cb(input logic g, input logic e, input string m);
    chk({7'h0, g}, {7'h0, e}, m);
  endtask
  task automatic end_of_test();
    if (nMismatch == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.writeReg(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.readReg(a);
  endtask
  task automatic pulseIn(input logic e, input string m);
    logic s;
    s = 1'b0;
    repeat (20) begin
      @(posedge clock);
      if (portDetectStart === 1'b1) s = 1'b1;
    end
    cb(s, e, m);
  endtask
  // Read results land here, oldest expectation first
  always @(posedge clock) begin
    if (rdValid === 1'b1) begin
      chk(rdData, expQ.size() > 0 ? expQ.pop_front() : 8'hXX, "read");
    end
  end
  initial begin
    cyc(95000);
    nMismatch++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h996F));
    cyc(3);
    cb(indicatorEnable, 1'b1, "ind in reset");
    chk(convCfg, `CTC_RST_CONV, "conv in reset");
    cyc(7);
    reset <= 1'b0;
    cyc(4);
    rd(`CTC_OFS_TIMER, `CTC_RST_TIMER);
    rd(`CTC_OFS_CHGWD, `CTC_RST_CHGWD);
    rd(`CTC_OFS_CONV, `CTC_RST_CONV);
    for (int i = 0; i < 2; i++) begin
      host.q = 10 + 4 * i;
      t = (8'($urandom) & 8'hDF) | (i ? 8'h10 : 8'h00);
      c = 8'($urandom) & 8'hFB;
      v = 8'($urandom) & 8'h7F;
      inputSourceType <= i ? 3'h3 : 3'($urandom);
      batteryOvpFault <= 1'($urandom);
      wr(`CTC_OFS_TIMER, t);
      wr(`CTC_OFS_CHGWD, c);
      wr(`CTC_OFS_CONV, v);
      rd(`CTC_OFS_TIMER, t);
      rd(`CTC_OFS_CHGWD, c);
      rd(`CTC_OFS_CONV, v);
      cb(indicatorEnable, !t[7], "ind");
      cb(dedicatedPortBias, t[4] && inputSourceType == 3'h3, "bias");
      cb(batteryDischarge, c[6] | batteryOvpFault & c[7], "dis");
      cb(midNodeDischarge, c[3], "mid");
      cb(chargeAllowed, c[5], "chg");
      chk(convCfg, v, "conv");
    end
    host.q = 10;
    wr(`CTC_OFS_TIMER, 8'h5C);
    inputPlugged <= 1'b1;
    pulseIn(1'b1, "auto detect");
    inputPlugged <= 1'b0;
    wr(`CTC_OFS_TIMER, 8'h1C);
    inputPlugged <= 1'b1;
    pulseIn(1'b0, "detect off");
    wr(`CTC_OFS_TIMER, 8'h3C);
    rd(`CTC_OFS_TIMER, 8'h3C);
    detectDone <= 1'b1;
    cyc(1);
    detectDone <= 1'b0;
    rd(`CTC_OFS_TIMER, 8'h1C);
    wr(`CTC_OFS_CHGWD, 8'hA0);
    wr(`CTC_OFS_TIMER, 8'h5E);
    thermalRegActive <= 1'b1;
    inPrecharge <= 1'b1;
    cyc(2400);
    cb(safetyTimerExpired, 1'b0, "half speed");
    cyc(1200);
    cb(safetyTimerExpired, 1'b1, "pre limit");
    cb(chargeAllowed, 1'b0, "chg stop");
    inPrecharge <= 1'b0;
    wr(`CTC_OFS_TIMER, 8'h5A);
    cb(chargeAllowed, 1'b1, "chg again");
    inPrecharge <= 1'b1;
    cyc(3600);
    cb(safetyTimerExpired, 1'b0, "timers off");
    inPrecharge <= 1'b0;
    thermalRegActive <= 1'b0;
    wr(`CTC_OFS_TIMER, 8'h83);
    wr(`CTC_OFS_CHGWD, 8'hA5);
    cyc(11500);
    cb(watchdogFault, 1'b0, "wd early");
    cyc(1000);
    cb(watchdogFault, 1'b1, "wd expiry");
    rd(`CTC_OFS_TIMER, 8'hD7);
    rd(`CTC_OFS_CHGWD, 8'hA1);
    rd(`CTC_OFS_STATUS, 8'h01);
    wr(`CTC_OFS_STATUS, 8'h01);
    rd(`CTC_OFS_STATUS, 8'h00);
    wr(`CTC_OFS_CONV, 8'h80);
    rd(`CTC_OFS_TIMER, `CTC_RST_TIMER);
    rd(`CTC_OFS_CONV, `CTC_RST_CONV);
    rd(8'h20, 8'h00);
    chk(convCfg, `CTC_RST_CONV, "restore");
    end_of_test();
  end
endmodule // tb_top
